// [dv/swdt_osc_model.sv]
// Low-frequency oscillator model driving the watchdog tick pin
module swdt_osc_model
#(
  parameter int HALF = 4
)
(
  // Clock
  input  wire logic aclk,
  // Control and pin
  input  wire logic run,
  output logic      low_freq_internal_osc
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  initial low_freq_internal_osc = 1'b0;
  // Runs far faster than silicon so that a 1:32 period fits a short run
  always @(posedge aclk)
  begin
    if (run && ph == HALF - 1)
    begin
      ph <= 0;
      low_freq_internal_osc <= ~low_freq_internal_osc;
    end
    else if (run)
      ph <= ph + 1;
  end
endmodule

// [dv/tb_swdt_top.sv]
// Self-checking bench: mode table, flags, interrupt and clear sources
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t value mismatch", $time); end end
module tb_swdt_top import swdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, osc_run;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, internal_osc_divider_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wdt_mode_config, resp;
  logic        low_freq_internal_osc, crystal_clock_sel, clear_watchdog_instr;
  logic        sleep_mode, osc_fail, osc_startup_timer, wdt_reset_req;
  logic        wdt_wake_req, timeout_flag_n, powerdown_flag_n, irq;
  int          bad_count = 0, cmp_count = 0, n_rst = 0, n_wake = 0;
  int          cyc, k, t, kind;
  typedef struct packed {
    logic [1:0] mode;
    logic       en;
    logic       slp;
    logic [4:0] ps;
    logic [1:0] ex;
  } swdt_row_t;
  // Expected event: 0 none, 1 reset request, 2 wake request
  swdt_row_t   rows [8] = '{
    '{2'h3, 1'b0, 1'b0, 5'h00, 2'h1},
    '{2'h3, 1'b0, 1'b1, 5'h01, 2'h2},
    '{2'h2, 1'b0, 1'b0, 5'h00, 2'h1},
    '{2'h2, 1'b1, 1'b1, 5'h00, 2'h0},
    '{2'h1, 1'b1, 1'b1, 5'h00, 2'h2},
    '{2'h1, 1'b0, 1'b0, 5'h00, 2'h0},
    '{2'h1, 1'b1, 1'b0, 5'h13, 2'h1},
    '{2'h0, 1'b1, 1'b0, 5'h1F, 2'h0}
  };

  swdt_top swdt_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .low_freq_internal_osc, .wdt_mode_config,
    .crystal_clock_sel, .internal_osc_divider_select, .clear_watchdog_instr,
    .sleep_mode, .osc_fail, .osc_startup_timer, .wdt_reset_req,
    .wdt_wake_req, .timeout_flag_n, .powerdown_flag_n, .irq);
  swdt_osc_model swdt_osc_model_i (.aclk, .run(osc_run),
    .low_freq_internal_osc);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    if (wdt_reset_req === 1'b1)
      n_rst <= n_rst + 1;
    if (wdt_wake_req === 1'b1)
      n_wake <= n_wake + 1;
  end

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic fail_to();
    bad_count++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    results();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, db;
    db = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 64 && !db; n++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      db = s_axi_bvalid & s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (db)
        s_axi_bready <= 1'b0;
    end
    if (!db)
      fail_to();
  endtask

  task automatic rd(input logic [7:0] a);
    bit ta, db;
    db = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 64 && !db; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      db = s_axi_rvalid & s_axi_rready;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (db)
        s_axi_rready <= 1'b0;
    end
    if (!db)
      fail_to();
  endtask

  // Watches the pulse counters; pulses are one cycle wide
  task automatic wait_evt(input int lim);
    int r0, w0;
    r0 = n_rst;
    w0 = n_wake;
    kind = 0;
    for (cyc = 0; cyc < lim && kind == 0; cyc++)
    begin
      @(negedge aclk);
      if (n_rst != r0)
        kind = 1;
      else if (n_wake != w0)
        kind = 2;
    end
    // Hand back on a rising edge so that callers drive on it
    @(posedge aclk);
  endtask

  task automatic clr();
    @(posedge aclk);
    clear_watchdog_instr <= 1'b1;
    @(posedge aclk);
    clear_watchdog_instr <= 1'b0;
  endtask

  initial
  begin
    repeat (100000) @(posedge aclk);
    fail_to();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb, internal_osc_divider_select} = 40'h0000000F0;
    {wdt_mode_config, crystal_clock_sel, clear_watchdog_instr} = 4'h0;
    {sleep_mode, osc_fail, osc_startup_timer, osc_run} = 4'h1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SWDT_CTRL_OFS);
    `CHK(rdat[7:0], 8'h16)
    `CHK(resp, SWDT_RESP_OKAY)
    wr(SWDT_CTRL_OFS, 32'h000000FF);
    rd(SWDT_CTRL_OFS);
    `CHK(rdat[7:0], 8'h3F)
    rd(8'h10);
    `CHK(resp, SWDT_RESP_DECERR)
    $display("test reset_values done");
    foreach (rows[i])
    begin
      sleep_mode <= 1'b0;
      wdt_mode_config <= rows[i].mode;
      // Divider moves every row and must not disturb the count
      internal_osc_divider_select <= 4'(i);
      wr(SWDT_CTRL_OFS, {26'h0, rows[i].ps, rows[i].en});
      sleep_mode <= rows[i].slp;
      clr();
      t = (32 << (rows[i].ps > 5'h12 ? 5'h0 : rows[i].ps)) * 8;
      wait_evt(t + 100);
      `CHK(kind, int'(rows[i].ex))
      if (kind != 0)
        `CHK(cyc > t - 24 && cyc < t + 24, 1'b1)
      if (kind == 2)
        `CHK({timeout_flag_n, powerdown_flag_n}, 2'b00)
      if (kind == 1)
        `CHK({timeout_flag_n, powerdown_flag_n}, 2'b01)
    end
    $display("test mode_table done");
    sleep_mode <= 1'b0;
    wdt_mode_config <= SWDT_MODE_OFF;
    repeat (4) @(posedge aclk);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK({timeout_flag_n, powerdown_flag_n}, 2'b10)
    sleep_mode <= 1'b0;
    $display("test sleep_flags done");
    wr(SWDT_MASK_OFS, 32'h3);
    rd(SWDT_STAT_OFS);
    wdt_mode_config <= SWDT_MODE_ON;
    wr(SWDT_CTRL_OFS, 32'h0);
    clr();
    wait_evt(400);
    `CHK(kind, 1)
    repeat (3) @(negedge aclk);
    `CHK(irq, 1'b1)
    rd(SWDT_STAT_OFS);
    `CHK({rdat[9:8], rdat[1:0]}, 4'b1001)
    repeat (3) @(negedge aclk);
    `CHK(irq, 1'b0)
    wr(SWDT_MASK_OFS, 32'h0);
    wait_evt(400);
    `CHK(kind, 1)
    repeat (3) @(negedge aclk);
    `CHK(irq, 1'b0)
    $display("test irq done");
    // Clear instruction, osc fail and crystal start-up, each held alone, must keep the count from expiring
    for (k = 0; k < 3; k++)
    begin
      @(posedge aclk);
      clear_watchdog_instr <= (k == 0);
      osc_fail <= (k == 1);
      osc_startup_timer <= (k == 2);
      crystal_clock_sel <= (k == 2);
      wait_evt(600);
      `CHK(kind, 0)
    end
    // Start-up hold on a crystal clock is still applied here
    rd(SWDT_CNT_OFS);
    `CHK(rdat, 32'h00000000)
    $display("test clear_sources done");
    wr(SWDT_CTRL_OFS, 32'h0000003F);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SWDT_CTRL_OFS);
    `CHK(rdat[7:0], 8'h16)
    $display("test mid_reset done");
    results();
  end
endmodule

// [src/swdt_pkg.sv]
// Package: register map, field layout, reset values and timing of the watchdog
package swdt_pkg;
  // Register byte offsets
  localparam logic [7:0]  SWDT_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  SWDT_STAT_OFS    = 8'h04;
  localparam logic [7:0]  SWDT_MASK_OFS    = 8'h08;
  localparam logic [7:0]  SWDT_CNT_OFS     = 8'h0C;
  // Control register fields
  localparam int          SWDT_EN_BIT      = 0;
  localparam int          SWDT_PS_LSB      = 1;
  localparam int          SWDT_PS_MSB      = 5;
  localparam logic [4:0]  SWDT_PS_RST      = 5'h0B;
  localparam logic        SWDT_EN_RST      = 1'b0;
  localparam logic [4:0]  SWDT_PS_MAX      = 5'h12;
  localparam logic [4:0]  SWDT_PS_SHIFT    = 5'h05;
  // Status register fields
  localparam int          SWDT_ST_RST_BIT  = 0;
  localparam int          SWDT_ST_WAKE_BIT = 1;
  localparam int          SWDT_ST_TO_BIT   = 8;
  localparam int          SWDT_ST_PD_BIT   = 9;
  localparam logic [1:0]  SWDT_IRQ_RST     = 2'h0;
  // Prescale counter
  localparam int          SWDT_CNT_W       = 23;
  localparam logic [22:0] SWDT_MIN_LAST    = 23'h00001F;
  // Oscillator figures: 31 kHz base, 1 ms nominal interval
  localparam int          SWDT_LF_KHZ      = 31;
  localparam int          SWDT_BASE_MS     = 1;
  // Mode configuration codes
  localparam logic [1:0]  SWDT_MODE_OFF    = 2'h0;
  localparam logic [1:0]  SWDT_MODE_SW     = 2'h1;
  localparam logic [1:0]  SWDT_MODE_AWAKE  = 2'h2;
  localparam logic [1:0]  SWDT_MODE_ON     = 2'h3;
  // AXI responses
  localparam logic [1:0]  SWDT_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SWDT_RESP_DECERR = 2'h3;
endpackage

// [src/swdt_top.sv]
// Watchdog timer with AXI4-Lite control registers and sleep wake-up
// Operation
// - Time-out while active and awake raises a system reset request
// - Counter advances on ticks of the 31 kHz low-frequency oscillator
// - Mode 11 keeps the watchdog active always, software enable ignored
// - Mode 10 runs the watchdog awake only, off during sleep
// - Mode 01 lets the software enable bit start or stop it
// - Mode 00 disables it; enable bit ignored outside mode 01
// - Period code n gives ratio 32 times two to the n, up to 10010
// - Reserved period codes 10011 to 11111 use the minimum ratio 1:32
// - Period select resets to 01011, about two seconds
// - Count clears on reset, clear, sleep in/out, osc fail, disable, startup
// - Sleep entry clears the count; counting resumes if sleep-active
// - Sleep exit clears; crystal clocks hold zero until startup timer ends
// - Time-out in sleep wakes the device, no reset, updates status flags
// - Oscillator divider changes leave count and running state alone
// - Control bits 7-6 read zero, period bits 5-1, enable bit 0
// - Sleep entry sets time-out flag and clears power-down flag
//
// The AXI4-Lite register port and the address map were left to the implementer.
module swdt_top
  import swdt_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Oscillator pin and configuration
  input  wire logic        low_freq_internal_osc,
  input  wire logic [1:0]  wdt_mode_config,
  input  wire logic        crystal_clock_sel,
  input  wire logic [3:0]  internal_osc_divider_select,
  // CPU core and oscillator monitor
  input  wire logic        clear_watchdog_instr,
  input  wire logic        sleep_mode,
  input  wire logic        osc_fail,
  input  wire logic        osc_startup_timer,
  // Reset and wake logic
  output logic             wdt_reset_req,
  output logic             wdt_wake_req,
  output logic             timeout_flag_n,
  output logic             powerdown_flag_n,
  output logic             irq
);

  // Last count of the selected ratio; reserved codes fall back to 1:32
  function automatic logic [SWDT_CNT_W-1:0] last_count(input logic [4:0] ps);
    logic [23:0] ratio;
    ratio = 24'h000001 << (ps + SWDT_PS_SHIFT);
    if (ps > SWDT_PS_MAX)
    begin
      last_count = SWDT_MIN_LAST;
    end
    else
    begin
      last_count = ratio[SWDT_CNT_W-1:0] - 23'h000001;
    end
  endfunction

  // AXI state
  logic        awready_reg, awready_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        wready_reg, wready_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  // Register state
  logic [4:0]  ps_reg, ps_next;
  logic        sw_en_reg, sw_en_next;
  logic [1:0]  stat_reg, stat_next;
  logic [1:0]  mask_reg, mask_next;
  logic        irq_reg, irq_next;
  // Watchdog core state
  logic        lf_s1_reg, lf_s2_reg, lf_prev_reg;
  logic [SWDT_CNT_W-1:0] cnt_reg, cnt_next;
  logic        sleep_prev_reg;
  logic        to_n_reg, to_n_next;
  logic        pd_n_reg, pd_n_next;
  logic        rst_req_reg, rst_req_next;
  logic        wake_reg, wake_next;
  // Decoded terms
  logic        lf_tick, active, clr_cnt, hit, timeout;
  logic        sleep_in, sleep_out, do_write, do_read;
  logic [SWDT_CNT_W-1:0] last;

  always_comb
  begin
    lf_tick   = lf_s2_reg & ~lf_prev_reg;
    sleep_in  = sleep_mode & ~sleep_prev_reg;
    sleep_out = ~sleep_mode & sleep_prev_reg;
    case (wdt_mode_config)
      SWDT_MODE_ON:    active = 1'b1;
      SWDT_MODE_AWAKE: active = ~sleep_mode;
      SWDT_MODE_SW:    active = sw_en_reg;
      default:         active = 1'b0;
    endcase
    // Divider select does not appear here on purpose
    clr_cnt = clear_watchdog_instr | sleep_in | sleep_out | osc_fail
            | ~active | (osc_startup_timer & crystal_clock_sel);
    last    = last_count(ps_reg);
    hit     = (cnt_reg == last);
    timeout = lf_tick & active & hit & ~clr_cnt;
    do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
    do_read  = s_axi_arvalid & arready_reg;
  end

  // Watchdog core next state
  always_comb
  begin
    cnt_next     = cnt_reg;
    to_n_next    = to_n_reg;
    pd_n_next    = pd_n_reg;
    rst_req_next = 1'b0;
    wake_next    = 1'b0;
    if (clr_cnt)
    begin
      cnt_next = '0;
    end
    else if (lf_tick)
    begin
      cnt_next = hit ? '0 : cnt_reg + 23'h000001;
    end
    if (sleep_in)
    begin
      to_n_next = 1'b1;
      pd_n_next = 1'b0;
    end
    if (timeout)
    begin
      to_n_next = 1'b0;
      if (sleep_mode)
      begin
        wake_next = 1'b1;
      end
      else
      begin
        rst_req_next = 1'b1;
        pd_n_next    = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    // Synchroniser carries no reset value dependence on the pin
    lf_s1_reg   <= low_freq_internal_osc;
    lf_s2_reg   <= lf_s1_reg;
    lf_prev_reg <= lf_s2_reg;
    if (!aresetn)
    begin
      cnt_reg        <= '0;
      sleep_prev_reg <= 1'b0;
      to_n_reg       <= 1'b1;
      pd_n_reg       <= 1'b1;
      rst_req_reg    <= 1'b0;
      wake_reg       <= 1'b0;
    end
    else
    begin
      cnt_reg        <= cnt_next;
      sleep_prev_reg <= sleep_mode;
      to_n_reg       <= to_n_next;
      pd_n_reg       <= pd_n_next;
      rst_req_reg    <= rst_req_next;
      wake_reg       <= wake_next;
    end
  end

  // Bus and register next state
  always_comb
  begin
    awready_next = awready_reg;
    aw_addr_next = aw_addr_reg;
    wready_next  = wready_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    ps_next      = ps_reg;
    sw_en_next   = sw_en_reg;
    mask_next    = mask_reg;
    stat_next    = stat_reg;
    if (s_axi_awvalid && awready_reg)
    begin
      awready_next = 1'b0;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg)
    begin
      wready_next = 1'b0;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write)
    begin
      awready_next = 1'b1;
      wready_next  = 1'b1;
      bvalid_next  = 1'b1;
      bresp_next   = SWDT_RESP_OKAY;
      case (aw_addr_reg)
        SWDT_CTRL_OFS:
        begin
          if (w_strb_reg[0])
          begin
            ps_next    = w_data_reg[SWDT_PS_MSB:SWDT_PS_LSB];
            sw_en_next = w_data_reg[SWDT_EN_BIT];
          end
        end
        SWDT_MASK_OFS:
        begin
          if (w_strb_reg[0])
          begin
            mask_next = w_data_reg[1:0];
          end
        end
        SWDT_STAT_OFS, SWDT_CNT_OFS: bresp_next = SWDT_RESP_OKAY;
        default: bresp_next = SWDT_RESP_DECERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (do_read)
    begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = 32'h00000000;
      rresp_next   = SWDT_RESP_OKAY;
      case (s_axi_araddr)
        SWDT_CTRL_OFS:
        begin
          rdata_next[SWDT_PS_MSB:SWDT_PS_LSB] = ps_reg;
          rdata_next[SWDT_EN_BIT]             = sw_en_reg;
        end
        SWDT_STAT_OFS:
        begin
          rdata_next[1:0]            = stat_reg;
          rdata_next[SWDT_ST_TO_BIT] = to_n_reg;
          rdata_next[SWDT_ST_PD_BIT] = pd_n_reg;
          stat_next                  = 2'h0;
        end
        SWDT_MASK_OFS: rdata_next[1:0] = mask_reg;
        SWDT_CNT_OFS:  rdata_next[SWDT_CNT_W-1:0] = cnt_reg;
        default:       rresp_next = SWDT_RESP_DECERR;
      endcase
    end
    // Events win over the read that clears them
    if (rst_req_reg)
    begin
      stat_next[SWDT_ST_RST_BIT] = 1'b1;
    end
    if (wake_reg)
    begin
      stat_next[SWDT_ST_WAKE_BIT] = 1'b1;
    end
    irq_next = |(stat_reg & mask_reg);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      aw_addr_reg <= 8'h00;
      wready_reg  <= 1'b1;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SWDT_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= SWDT_RESP_OKAY;
      ps_reg      <= SWDT_PS_RST;
      sw_en_reg   <= SWDT_EN_RST;
      stat_reg    <= SWDT_IRQ_RST;
      mask_reg    <= SWDT_IRQ_RST;
      irq_reg     <= 1'b0;
    end
    else
    begin
      awready_reg <= awready_next;
      aw_addr_reg <= aw_addr_next;
      wready_reg  <= wready_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ps_reg      <= ps_next;
      sw_en_reg   <= sw_en_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      irq_reg     <= irq_next;
    end
  end

  assign s_axi_awready    = awready_reg;
  assign s_axi_wready     = wready_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rdata      = rdata_reg;
  assign s_axi_rresp      = rresp_reg;
  assign wdt_reset_req    = rst_req_reg;
  assign wdt_wake_req     = wake_reg;
  assign timeout_flag_n   = to_n_reg;
  assign powerdown_flag_n = pd_n_reg;
  assign irq              = irq_reg;

  chk_awake_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && !sleep_mode |=> wdt_reset_req && !wdt_wake_req)
    else $error("awake time-out gave no reset");
  chk_sleep_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && sleep_mode |=> wdt_wake_req && !wdt_reset_req && !timeout_flag_n)
    else $error("sleep time-out did not wake");
  chk_mode_off: assert property (@(posedge aclk) disable iff (!aresetn)
    wdt_mode_config == SWDT_MODE_OFF |=> cnt_reg == '0 && !wdt_reset_req)
    else $error("disabled watchdog counted");
  chk_awake_only: assert property (@(posedge aclk) disable iff (!aresetn)
    wdt_mode_config == SWDT_MODE_AWAKE && sleep_mode |-> !timeout)
    else $error("mode 10 timed out in sleep");
  chk_clear_instr: assert property (@(posedge aclk) disable iff (!aresetn)
    clear_watchdog_instr |=> cnt_reg == '0)
    else $error("clear did not zero count");
  chk_reserved_ps: assert property (@(posedge aclk) disable iff (!aresetn)
    ps_reg > SWDT_PS_MAX |-> last == SWDT_MIN_LAST)
    else $error("reserved period not minimum");
  chk_ps_default: assert property (@(posedge aclk)
    !aresetn |=> ps_reg == SWDT_PS_RST && !sw_en_reg)
    else $error("period default wrong");
  chk_sleep_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_in && !timeout |=> timeout_flag_n && !powerdown_flag_n)
    else $error("sleep entry flags wrong");
  chk_crystal_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (osc_startup_timer && crystal_clock_sel) [*2] |-> cnt_reg == '0)
    else $error("count moved during startup");
  chk_ctrl_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    do_read && s_axi_araddr == SWDT_CTRL_OFS |=> s_axi_rdata[31:6] == '0)
    else $error("control upper bits not zero");
  chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    !lf_tick && !clr_cnt |=> $stable(cnt_reg))
    else $error("count moved without tick");

endmodule
